// ### bpc_tester.sv
// Purpose: Pattern tester configuration, transmit generator and receive checker
// Assumes: One line bit per clock on each path; strobes on the register port are one cycle
// Notes: Control strobe bits act on rising edges of their stored value
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module bpc_tester (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic tx_data_o,
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    input wire logic rx_data_i,
    input wire logic rx_valid_i,
    output logic in_sync_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Shared decode

    function automatic logic is_prbs(input logic [2:0] sel);
        is_prbs = !(sel == bpc_pkg::PAT_REPEAT || sel == bpc_pkg::PAT_ALT_WORD ||
                    sel == bpc_pkg::PAT_DALY);
    endfunction

    // Feedback bit of the selected polynomial on a 20-bit history
    function automatic logic prbs_fb(input logic [2:0] sel, input logic [19:0] s);
        case (sel)
            bpc_pkg::PAT_PRBS7: prbs_fb = s[6] ^ s[5];
            bpc_pkg::PAT_PRBS11: prbs_fb = s[10] ^ s[8];
            bpc_pkg::PAT_PRBS15: prbs_fb = s[14] ^ s[13];
            bpc_pkg::PAT_QRSS: prbs_fb = s[19] ^ s[16];
            bpc_pkg::PAT_PRBS9: prbs_fb = s[8] ^ s[4];
            default: prbs_fb = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [7:0] alt_rate_r;
    logic [31:0] pat_r;
    bpc_pkg::bpc_ctrl_s ctrl_r;
    logic load_pls_r;
    logic latch_pls_r;
    logic receiver_realign_strobe_pls_r;
    logic [7:0] rdata_r;
    logic [31:0] bit_lat_r;
    logic [23:0] err_lat_r;
    bpc_pkg::bpc_sync_e sync_st_r;
    logic buf_in_ready;

    wire wr_en = wr_i && ce_i;
    wire wr_alt = wr_en && (addr_i == bpc_pkg::OFF_ALT_RATE);
    wire wr_pat = wr_en && (addr_i >= bpc_pkg::OFF_PAT0) && (addr_i <= bpc_pkg::OFF_PAT3);
    wire [1:0] pat_byte = 2'(addr_i - bpc_pkg::OFF_PAT0);
    wire wr_ctrl = wr_en && (addr_i == bpc_pkg::OFF_CTRL);
    wire [7:0] ctrl_q = ctrl_r;

    // Rising edge of a strobe is judged against the stored value
    wire load_rise = wr_ctrl && wdata_i[bpc_pkg::CTRL_LOAD_BIT] && !ctrl_q[bpc_pkg::CTRL_LOAD_BIT];
    wire latch_rise = wr_ctrl && wdata_i[bpc_pkg::CTRL_LATCH_BIT] && !ctrl_q[bpc_pkg::CTRL_LATCH_BIT];
    wire receiver_realign_strobe_rise = wr_ctrl && wdata_i[bpc_pkg::CTRL_RECEIVER_REALIGN_STROBE_BIT] &&
                       !ctrl_q[bpc_pkg::CTRL_RECEIVER_REALIGN_STROBE_BIT];

    wire [7:0] status_q = {6'h00, !buf_in_ready, sync_st_r == bpc_pkg::ST_SYNC};
    wire [1:0] bc_idx = 2'(addr_i - bpc_pkg::OFF_BITCNT0);
    wire [1:0] ec_idx = 2'(addr_i - bpc_pkg::OFF_ERRCNT0);
    wire in_bc = (addr_i >= bpc_pkg::OFF_BITCNT0) && (addr_i <= bpc_pkg::OFF_BITCNT3);
    wire in_ec = (addr_i >= bpc_pkg::OFF_ERRCNT0) && (addr_i <= bpc_pkg::OFF_ERRCNT2);
    wire [7:0] rd_mux =
        (addr_i == bpc_pkg::OFF_ALT_RATE) ? alt_rate_r :
        (addr_i >= bpc_pkg::OFF_PAT0 && addr_i <= bpc_pkg::OFF_PAT3) ? pat_r[8*pat_byte +: 8] :
        (addr_i == bpc_pkg::OFF_CTRL) ? ctrl_q :
        (addr_i == bpc_pkg::OFF_STATUS) ? status_q :
        in_bc ? bit_lat_r[8*bc_idx +: 8] :
        in_ec ? err_lat_r[8*ec_idx +: 8] :
        8'h00;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            alt_rate_r <= bpc_pkg::RST_ALT_RATE;
            pat_r <= bpc_pkg::RST_PAT;
            ctrl_r <= bpc_pkg::RST_CTRL;
            load_pls_r <= 1'b0;
            latch_pls_r <= 1'b0;
            receiver_realign_strobe_pls_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (ce_i) begin
            if (wr_alt) begin
                alt_rate_r <= wdata_i;
            end
            if (wr_pat) begin
                pat_r[8*pat_byte +: 8] <= wdata_i;
            end
            if (wr_ctrl) begin
                ctrl_r <= wdata_i;
            end
            load_pls_r <= load_rise;
            latch_pls_r <= latch_rise;
            receiver_realign_strobe_pls_r <= receiver_realign_strobe_rise;
            // Read data stand only in the cycle after the strobe
            rdata_r <= rd_i ? rd_mux : 8'h00;
        end
    end

    assign rdata_o = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Transmit generator

    logic [2:0] tx_sel_r;
    logic [31:0] tx_pat_r;
    logic [19:0] tx_lfsr_r;
    logic [3:0] tx_zrun_r;
    logic [4:0] tx_idx_r;
    logic [7:0] tx_wcnt_r;
    logic tx_alt_hi_r;
    bpc_pkg::bpc_beat_s beat_in;
    bpc_pkg::bpc_beat_s beat_out;

    wire tx_fb = prbs_fb(tx_sel_r, tx_lfsr_r);
    // QRSS never sends more than fourteen zeros in a row
    wire qrss_force = (tx_sel_r == bpc_pkg::PAT_QRSS) && !tx_fb && (tx_zrun_r == bpc_pkg::QRSS_MAX_ZEROS);
    wire [4:0] alt_idx = {tx_alt_hi_r, tx_idx_r[3:0]};
    // Daly table is not held here, so that select sends all ones
    wire gen_bit = (tx_sel_r == bpc_pkg::PAT_REPEAT) ? tx_pat_r[tx_idx_r] :
                   (tx_sel_r == bpc_pkg::PAT_ALT_WORD) ? tx_pat_r[alt_idx] :
                   (tx_sel_r == bpc_pkg::PAT_DALY) ? 1'b1 :
                   (tx_fb | qrss_force);
    wire tx_push = buf_in_ready && ce_i;
    wire alt_word_end = (tx_sel_r == bpc_pkg::PAT_ALT_WORD) && (tx_idx_r[3:0] == bpc_pkg::ALT_LAST_IDX);

    assign beat_in.line_bit = gen_bit ^ ctrl_r.tx_invert_enable;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tx_sel_r <= bpc_pkg::PAT_PRBS7;
            tx_pat_r <= bpc_pkg::RST_PAT;
            tx_lfsr_r <= bpc_pkg::LFSR_SEED;
            tx_zrun_r <= 4'h0;
            tx_idx_r <= 5'h00;
            tx_wcnt_r <= 8'h00;
            tx_alt_hi_r <= 1'b0;
        end else if (ce_i) begin
            if (load_pls_r) begin
                // The generator only changes pattern on a load
                tx_sel_r <= ctrl_r.pattern_select;
                tx_pat_r <= pat_r;
                tx_lfsr_r <= bpc_pkg::LFSR_SEED;
                tx_zrun_r <= 4'h0;
                tx_idx_r <= 5'h00;
                tx_wcnt_r <= 8'h00;
                tx_alt_hi_r <= 1'b0;
            end else if (tx_push) begin
                tx_lfsr_r <= {tx_lfsr_r[18:0], tx_fb};
                tx_zrun_r <= gen_bit ? 4'h0 : tx_zrun_r + 4'h1;
                tx_idx_r <= (tx_idx_r == bpc_pkg::REP_LAST_IDX) ? 5'h00 : tx_idx_r + 5'h01;
                if (alt_word_end) begin
                    // Each 16-bit word repeats rate plus one times before switching
                    if (tx_wcnt_r == alt_rate_r) begin
                        tx_wcnt_r <= 8'h00;
                        tx_alt_hi_r <= !tx_alt_hi_r;
                    end else begin
                        tx_wcnt_r <= tx_wcnt_r + 8'h01;
                    end
                end
            end
        end
    end

    // A stall on the line path holds the generator, so no bit is lost
    bpc_buf2 #(
        .WIDTH($bits(bpc_pkg::bpc_beat_s))
    ) u_txbuf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .in_valid_i(1'b1),
        .in_ready_o(buf_in_ready),
        .in_data_i(beat_in),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(beat_out)
    );

    assign tx_data_o = beat_out.line_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Receive checker

    logic [31:0] rx_hist_r;
    logic [5:0] good_cnt_r;
    logic [2:0] bad_run_r;
    logic [31:0] bit_cnt_r;
    logic [23:0] err_cnt_r;

    wire rx_take = rx_valid_i && ce_i;
    wire rx_bit = rx_data_i ^ ctrl_r.rx_invert_enable;
    // Pseudorandom modes self-align on the received history; others predict with period 32
    wire rx_pred = is_prbs(ctrl_r.pattern_select) ?
                   prbs_fb(ctrl_r.pattern_select, rx_hist_r[19:0]) : rx_hist_r[31];
    wire rx_miss = rx_bit != rx_pred;
    wire in_sync = (sync_st_r == bpc_pkg::ST_SYNC);
    wire [31:0] bit_inc = {31'h0, rx_take && in_sync};
    wire [23:0] err_inc = {23'h0, rx_take && in_sync && rx_miss && (err_cnt_r != 24'hFFFFFF)};

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rx_hist_r <= 32'h0000_0000;
            good_cnt_r <= 6'h00;
            bad_run_r <= 3'h0;
            sync_st_r <= bpc_pkg::ST_HUNT;
        end else if (ce_i) begin
            if (rx_take) begin
                rx_hist_r <= {rx_hist_r[30:0], rx_bit};
            end
            if (receiver_realign_strobe_pls_r) begin
                sync_st_r <= bpc_pkg::ST_HUNT;
                good_cnt_r <= 6'h00;
                bad_run_r <= 3'h0;
            end else if (rx_take) begin
                case (sync_st_r)
                    bpc_pkg::ST_HUNT: begin
                        if (rx_miss) begin
                            good_cnt_r <= 6'h00;
                        end else if (good_cnt_r == bpc_pkg::SYNC_GOOD_BITS - 6'h01) begin
                            good_cnt_r <= 6'h00;
                            bad_run_r <= 3'h0;
                            sync_st_r <= bpc_pkg::ST_SYNC;
                        end else begin
                            good_cnt_r <= good_cnt_r + 6'h01;
                        end
                    end
                    bpc_pkg::ST_SYNC: begin
                        if (!rx_miss) begin
                            bad_run_r <= 3'h0;
                        end else if (bad_run_r == bpc_pkg::SYNC_LOSS_ERRS - 3'h1) begin
                            bad_run_r <= 3'h0;
                            sync_st_r <= bpc_pkg::ST_HUNT;
                        end else begin
                            bad_run_r <= bad_run_r + 3'h1;
                        end
                    end
                    default: sync_st_r <= bpc_pkg::ST_HUNT;
                endcase
            end
        end
    end

    // The bit arriving with the latch starts the new period, so none is lost
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            bit_cnt_r <= 32'h0000_0000;
            err_cnt_r <= 24'h000000;
            bit_lat_r <= 32'h0000_0000;
            err_lat_r <= 24'h000000;
        end else if (ce_i) begin
            if (latch_pls_r) begin
                bit_lat_r <= bit_cnt_r;
                err_lat_r <= err_cnt_r;
                bit_cnt_r <= bit_inc;
                err_cnt_r <= {23'h0, rx_take && in_sync && rx_miss};
            end else begin
                bit_cnt_r <= bit_cnt_r + bit_inc;
                err_cnt_r <= err_cnt_r + err_inc;
            end
        end
    end

    assign in_sync_o = in_sync;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_alt_rate_store: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_alt |=> alt_rate_r == $past(wdata_i))
        else $error("alternating rate not stored");
    a_pat_byte0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && addr_i == bpc_pkg::OFF_PAT0) |=> pat_r[7:0] == $past(wdata_i))
        else $error("pattern byte 0 wrong");
    a_pat_byte1: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && addr_i == bpc_pkg::OFF_PAT1) |=> pat_r[15:8] == $past(wdata_i))
        else $error("pattern byte 1 wrong");
    a_pat_byte2: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && addr_i == bpc_pkg::OFF_PAT2) |=> pat_r[23:16] == $past(wdata_i))
        else $error("pattern byte 2 wrong");
    a_pat_byte3: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_en && addr_i == bpc_pkg::OFF_PAT3) |=> pat_r[31:24] == $past(wdata_i))
        else $error("pattern byte 3 wrong");
    a_load_takes_pattern: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        load_rise |=> ##1
        (tx_sel_r == $past(ctrl_r.pattern_select) && tx_pat_r == $past(pat_r) && tx_idx_r == 5'h00))
        else $error("load did not take pattern");
    a_tx_invert_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tx_push && !load_pls_r && tx_sel_r == bpc_pkg::PAT_REPEAT) |->
        beat_in.line_bit == (tx_pat_r[tx_idx_r] ^ ctrl_r.tx_invert_enable))
        else $error("transmit inversion wrong");
    a_rx_invert_hist: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rx_take |=> rx_hist_r[0] == ($past(rx_data_i) ^ $past(ctrl_r.rx_invert_enable)))
        else $error("receive inversion wrong");
    a_daly_all_ones: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tx_sel_r == bpc_pkg::PAT_DALY) |-> gen_bit)
        else $error("pattern select decode wrong");
    a_latch_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (latch_pls_r && ce_i) |=> (bit_lat_r == $past(bit_cnt_r) && bit_cnt_r <= 32'h1))
        else $error("count latch wrong");
    a_receiver_realign_strobe_hunt: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (receiver_realign_strobe_rise) |=> ##1 (sync_st_r == bpc_pkg::ST_HUNT && good_cnt_r == 6'h00))
        else $error("receiver_realign_strobe did not restart hunt");
    a_strobe_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (load_pls_r && ce_i) |=> !load_pls_r)
        else $error("strobe pulse longer than one cycle");
    a_latch_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (latch_pls_r && ce_i) |=> !latch_pls_r)
        else $error("latch pulse longer than one cycle");
    a_held_no_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (wr_ctrl && ctrl_q[bpc_pkg::CTRL_LOAD_BIT]) |=> !load_pls_r)
        else $error("load pulse without rising bit");
    a_latch_err_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (latch_pls_r && ce_i) |=> err_lat_r == $past(err_cnt_r))
        else $error("error count latch wrong");

endmodule

// ### bpc_pkg.sv
// Purpose: Shared constants and types for the pattern tester configuration block
// Assumes: 8-bit register port, one bit per clock on each line path
// Notes: Offsets are byte addresses on the register port
package bpc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFF_ALT_RATE = 8'hDB;
    localparam logic [7:0] OFF_PAT0 = 8'hDC;
    localparam logic [7:0] OFF_PAT1 = 8'hDD;
    localparam logic [7:0] OFF_PAT2 = 8'hDE;
    localparam logic [7:0] OFF_PAT3 = 8'hDF;
    localparam logic [7:0] OFF_CTRL = 8'hE0;
    localparam logic [7:0] OFF_STATUS = 8'hE2;
    localparam logic [7:0] OFF_BITCNT0 = 8'hE3;
    localparam logic [7:0] OFF_BITCNT3 = 8'hE6;
    localparam logic [7:0] OFF_ERRCNT0 = 8'hE7;
    localparam logic [7:0] OFF_ERRCNT2 = 8'hE9;

    // Control field positions
    localparam int CTRL_LOAD_BIT = 7;
    localparam int CTRL_LATCH_BIT = 1;
    localparam int CTRL_RECEIVER_REALIGN_STROBE_BIT = 0;

    // Status field positions
    localparam int STAT_SYNC_BIT = 0;
    localparam int STAT_FULL_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_ALT_RATE = 8'h00;
    localparam logic [31:0] RST_PAT = 32'h0000_0000;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [19:0] LFSR_SEED = 20'hFFFFF;

    // Timing counts, in bits received or sent
    localparam logic [5:0] SYNC_GOOD_BITS = 6'h20;
    localparam logic [2:0] SYNC_LOSS_ERRS = 3'h4;
    localparam logic [3:0] QRSS_MAX_ZEROS = 4'hE;
    localparam logic [4:0] REP_LAST_IDX = 5'h1F;
    localparam logic [3:0] ALT_LAST_IDX = 4'hF;

    typedef enum logic [2:0] {
        PAT_PRBS7 = 3'h0,
        PAT_PRBS11 = 3'h1,
        PAT_PRBS15 = 3'h2,
        PAT_QRSS = 3'h3,
        PAT_REPEAT = 3'h4,
        PAT_ALT_WORD = 3'h5,
        PAT_DALY = 3'h6,
        PAT_PRBS9 = 3'h7
    } bpc_sel_e;

    typedef enum logic {
        ST_HUNT,
        ST_SYNC
    } bpc_sync_e;

    // Bit layout of tester_control_one, bit 7 down to bit 0
    typedef struct packed {
        logic pattern_load_strobe;
        logic tx_invert_enable;
        logic rx_invert_enable;
        logic [2:0] pattern_select;
        logic count_latch_strobe;
        logic receiver_realign_strobe;
    } bpc_ctrl_s;

    // One beat on the transmit line path
    typedef struct packed {
        logic line_bit;
    } bpc_beat_s;

endpackage

// ### bpc_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes: Full and empty are exact; data out comes from a register
`timescale 1ns/10ps
module bpc_buf2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("bpc_buf2 needs WIDTH of at least one");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [2];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;

    wire push = in_valid_i && in_ready_o && ce_i;
    wire pop = out_valid_o && out_ready_i && ce_i;

    assign in_ready_o = (count_r != 2'h2);
    assign out_valid_o = (count_r != 2'h0);
    assign out_data_o = mem_r[rd_ptr_r];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= in_data_i;
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

endmodule

// ### bpc_line_model.sv
// Purpose: Far side of the line, loops every taken transmit bit back to receive
// Assumes: One bit per clock; slow_i stalls the transmit side one cycle in four
// Notes: The receive bit toggles every cycle while no bit is valid
`timescale 1ns/10ps
module bpc_line_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic rx_data_o,
    output logic rx_valid_o
);
    logic [1:0] cnt_r;
    logic take;
    assign take = tx_valid_i && tx_ready_o;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_r <= 2'h0;
            tx_ready_o <= 1'b0;
            rx_valid_o <= 1'b0;
            rx_data_o <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 2'h1;
            tx_ready_o <= !(slow_i && cnt_r == 2'h2);
            rx_valid_o <= take;
            // Idle line must not look like a repeat of the last bit
            rx_data_o <= take ? tx_data_i : !rx_data_o;
        end
    end
endmodule

// ### bpc_tester_tb.sv
// Purpose: Self-checking bench for the pattern tester block
// Assumes: Line model loops transmit to receive, so the checker sees our own pattern
// Notes: Streams are matched at any phase, since the buffer holds bits across loads
`timescale 1ns/10ps
module bpc_tester_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic ce_i = 1'b1;
    logic slow = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic [7:0] rv;
    logic [31:0] pat;
    logic tx_data_o, tx_valid_o, tx_ready, rx_data, rx_valid, in_sync_o;
    int n_errors = 0;
    int num_checks = 0;
    logic got[$];
    logic expd[$];
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (tx_valid_o && tx_ready) got.push_back(tx_data_o);
    bpc_tester DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready), .rx_data_i(rx_data),
        .rx_valid_i(rx_valid), .in_sync_o(in_sync_o));
    bpc_line_model line (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .tx_data_i(tx_data_o),
        .tx_valid_i(tx_valid_o), .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask
    task automatic load_pat(input logic [31:0] p);
        pat = p;
        for (int i = 0; i < 4; i++) wr(bpc_pkg::OFF_PAT0 + 8'(i), p[8 * i +: 8]);
    endtask
    task automatic rep_exp(input logic inv);
        expd.delete();
        for (int i = 0; i < 32; i++) expd.push_back(pat[i] ^ inv);
    endtask
    // Stale bits from before a load are skipped, then two periods must match one phase
    task automatic stream(input string name, input int p);
        bit ok;
        bit hit;
        repeat (8) @(posedge clk_i);
        got.delete();
        for (int k = 0; k < 400 && got.size() < 2 * p; k++) @(posedge clk_i);
        hit = 0;
        for (int k = 0; k < p; k++) begin
            ok = got.size() >= 2 * p;
            for (int j = 0; j < 2 * p; j++) if (ok && got[j] !== expd[(j + k) % p]) ok = 0;
            hit |= ok;
        end
        check(name, 32'(hit), 32'h1);
    endtask
    task automatic wait_sync(input string name, input logic e);
        for (int k = 0; k < 300 && in_sync_o !== e; k++) @(posedge clk_i);
        check(name, 32'(in_sync_o), 32'(e));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_regs();
        wr(8'hD0, 8'h5A);
        rd(8'hD0);
        check("unmapped", 32'(rv), 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(bpc_pkg::OFF_ALT_RATE + 8'(i));
            check("reset value", 32'(rv), 32'h0);
        end
        wr(bpc_pkg::OFF_ALT_RATE, 8'hA5);
        load_pat(32'h1234_5678);
        rd(bpc_pkg::OFF_ALT_RATE);
        check("alt rate", 32'(rv), 32'hA5);
        for (int i = 0; i < 4; i++) begin
            rd(bpc_pkg::OFF_PAT0 + 8'(i));
            check("pattern byte", 32'(rv), 32'(pat[8 * i +: 8]));
        end
    endtask
    task automatic t_repeat();
        rep_exp(1'b0);
        wr(bpc_pkg::OFF_CTRL, 8'h10);
        wr(bpc_pkg::OFF_CTRL, 8'h90);
        slow <= 1'b1;
        stream("repeat stream", 32);
        slow <= 1'b0;
        // Load bit still set, so this write must not reload
        load_pat(32'hCAFE_F00D);
        wr(bpc_pkg::OFF_CTRL, 8'h90);
        stream("no reload", 32);
        wr(bpc_pkg::OFF_CTRL, 8'h10);
        wr(bpc_pkg::OFF_CTRL, 8'h90);
        rep_exp(1'b0);
        stream("reload", 32);
        wr(bpc_pkg::OFF_CTRL, 8'h10);
        wr(bpc_pkg::OFF_CTRL, 8'hD0);
        rep_exp(1'b1);
        stream("tx inverted", 32);
    endtask
    task automatic t_latch();
        wait_sync("sync repeat", 1'b1);
        wr(bpc_pkg::OFF_CTRL, 8'hD2);
        wr(bpc_pkg::OFF_CTRL, 8'hD0);
        wr(bpc_pkg::OFF_CTRL, 8'hD2);
        rd(bpc_pkg::OFF_BITCNT0);
        check("bit count", 32'(rv), 32'h4);
        rd(bpc_pkg::OFF_ERRCNT0);
        check("error count", 32'(rv), 32'h0);
    endtask
    task automatic t_rx_path();
        wr(bpc_pkg::OFF_CTRL, 8'h00);
        wr(bpc_pkg::OFF_CTRL, 8'h81);
        wait_sync("prbs sync", 1'b1);
        wr(bpc_pkg::OFF_CTRL, 8'h20);
        wait_sync("rx inverted", 1'b0);
        wr(bpc_pkg::OFF_CTRL, 8'h00);
        wait_sync("rx plain", 1'b1);
        wr(bpc_pkg::OFF_CTRL, 8'h01);
        @(posedge clk_i);
        #1 check("realign", 32'(in_sync_o), 32'h0);
        wait_sync("realigned", 1'b1);
    endtask
    task automatic t_codes();
        wr(bpc_pkg::OFF_ALT_RATE, 8'h00);
        for (int s = 0; s < 8; s++) begin
            wr(bpc_pkg::OFF_CTRL, 8'(s << 2));
            wr(bpc_pkg::OFF_CTRL, 8'h81 | 8'(s << 2));
            wait_sync("select sync", 1'b1);
        end
        wr(bpc_pkg::OFF_ALT_RATE, 8'h01);
        expd.delete();
        for (int h = 0; h < 2; h++) begin
            for (int r = 0; r < 2; r++) begin
                for (int i = 0; i < 16; i++) expd.push_back(pat[16 * h + i]);
            end
        end
        wr(bpc_pkg::OFF_CTRL, 8'h14);
        wr(bpc_pkg::OFF_CTRL, 8'h94);
        stream("alt word", 64);
    endtask
    // A write while the enable is low must leave the register as it was
    task automatic t_freeze();
        ce_i <= 1'b0;
        wr(bpc_pkg::OFF_ALT_RATE, 8'h3C);
        ce_i <= 1'b1;
        rd(bpc_pkg::OFF_ALT_RATE);
        check("rate held while frozen", 32'(rv), 32'h01);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Whole run is at most about six thousand cycles, so 1 ms means a hang
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset_regs();
        t_repeat();
        t_latch();
        t_rx_path();
        t_codes();
        t_freeze();
        report_and_stop();
    end
endmodule
